/* logic/tvic_regs.vh */
/*
 * Register offsets, field positions, reset values, vectors and timing
 * constants of the two-level vectored interrupt controller.
 * Assumes an AHB-Lite slave with 32-bit data, one register per word.
 */
// What this block does
// R1 - Select bit picks low level or edge
// R2 - Edge mode: high sample then low sets flag
// R3 - Vectoring clears external flag only in edge mode
// R4 - Timer overflow flags request; cleared on vectoring
// R5 - Serial request is rx or tx; never hardware-cleared
// R6 - Timer 2 request is overflow or external flag
// R7 - Software may set or clear every request flag
// R8 - Per-source enables plus one global enable
// R9 - Low handler preempted only by high level
// R10 - Level register bit map, 1 selects high
// R11 - Higher level first, then fixed polling order
// R12 - Flags sampled at state5_phase2, polled next cycle; the code polls them at the last clock of the same machine cycle
// R13 - Block call on level, non-final cycle, special instruction
// R14 - Blocked requests are not remembered
// R15 - Call pushes program counter, loads source vector
// R16 - Hardware call lasts two machine cycles
// R17 - Return from handler clears active level in progress
// R18 - External pin levels inverted and latched each cycle
// R19 - Requester holds pin levels one machine cycle
// R20 - Level requester holds request until call
// R21 - Single-source response between three and eight cycles
// R22 - Sequencer gives final-cycle and special flags, takes call
`ifndef TVIC_REGS_VH
`define TVIC_REGS_VH
`define TVIC_OFF_FLAGS   12'h000
`define TVIC_OFF_ENABLE  12'h004
`define TVIC_OFF_LEVEL   12'h008
`define TVIC_OFF_STATUS  12'h00C
`define TVIC_OFF_CTRL    12'h010
// Flags register fields.
`define TVIC_F_EXT0      0
`define TVIC_F_TMR0      1
`define TVIC_F_EXT1      2
`define TVIC_F_TMR1      3
`define TVIC_F_RX        4
`define TVIC_F_TX        5
`define TVIC_F_T2OV      6
`define TVIC_F_T2EX      7
// Enable register: bits 5..0 sources, bit 7 global enable.
`define TVIC_EN_GLOBAL   7
`define TVIC_LEVEL_MASK  8'h3F
`define TVIC_ENABLE_MASK 8'hBF
// Control register fields.
`define TVIC_C_EDGE0     0
`define TVIC_C_EDGE1     1
`define TVIC_RESET_BYTE  8'h00
// Machine cycle is 12 clocks; sampling slot within it.
`define TVIC_MC_LAST     4'hB
`define TVIC_MC_SAMPLE   4'h9
`define TVIC_VEC0        16'h0003
`define TVIC_VEC_STEP    16'h0008
`define TVIC_CALL_CYCLES 2'h2
`endif

/* logic/tvic_ctrl.v */
/*
 * Six-source two-level vectored interrupt controller with AHB-Lite
 * register access. Assumes a CPU sequencer that reports final cycle and
 * special instructions once per machine cycle and takes call requests.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tvic_regs.vh"
module tvic_ctrl (
    input  wire        hclk,             // 40 MHz clock
    input  wire        hresetn,          // async reset, active low
    input  wire        hsel,             // slave select
    input  wire [11:0] haddr,            // byte address
    input  wire [1:0]  htrans,           // transfer type
    input  wire        hwrite,           // write
    input  wire [2:0]  hsize,            // transfer size
    input  wire        hready,           // bus ready in
    input  wire [31:0] hwdata,           // write data
    output wire [31:0] hrdata,           // read data
    output wire        hreadyout,        // always ready
    output wire        hresp,            // always OKAY
    input  wire        ext_request_pin_0, // external request 0 pin
    input  wire        ext_request_pin_1, // external request 1 pin
    input  wire        timer0_rollover,  // timer 0 rollover pulse
    input  wire        timer1_rollover,  // timer 1 rollover pulse
    input  wire        timer2_rollover,  // timer 2 overflow pulse
    input  wire        timer2_ext_event, // timer 2 external pulse
    input  wire        rx_done,          // receive done pulse
    input  wire        tx_done,          // transmit done pulse
    input  wire        final_cycle,      // instruction in final cycle
    input  wire        special_instr,    // return or enable/level access
    input  wire        handler_return,   // return_from_handler executed
    output reg         call_req,         // long_subroutine_call request
    output reg  [15:0] call_vector,      // vector address of call
    output wire        machine_cycle_end // last clock of machine cycle
);
    reg  [3:0]  phase;
    reg  [1:0]  pin0_sync;
    reg  [1:0]  pin1_sync;
    reg         pin0_prev;
    reg         pin1_prev;
    reg  [7:0]  flags;
    reg  [7:0]  source_enable_reg;
    reg  [7:0]  level_select_reg;
    reg  [1:0]  ctrl;
    reg  [5:0]  sampled;
    reg  [1:0]  in_progress;        // bit 1 high level, bit 0 low level
    reg  [1:0]  call_cnt;
    reg  [2:0]  call_src;
    reg         call_high;
    reg         dp_write;
    reg         dp_read;
    reg  [11:0] dp_addr;
    reg  [31:0] rdata;
    reg  [7:0]  next_flags;
    reg  [2:0]  sel_src;
    reg         sel_valid;
    reg         sel_high;
    integer     i;

    wire mc_end    = (phase == `TVIC_MC_LAST);
    wire sample_pt = (phase == `TVIC_MC_SAMPLE);
    wire edge0     = ctrl[`TVIC_C_EDGE0];
    wire edge1     = ctrl[`TVIC_C_EDGE1];
    wire calling   = (call_cnt != 2'h0);
    wire take_call = mc_end && sel_valid && final_cycle && !special_instr && !calling; // R13 R21
    wire [5:0] req = {flags[`TVIC_F_T2OV] | flags[`TVIC_F_T2EX], // R6
                      flags[`TVIC_F_RX] | flags[`TVIC_F_TX],     // R5
                      flags[`TVIC_F_TMR1], flags[`TVIC_F_EXT1],
                      flags[`TVIC_F_TMR0], flags[`TVIC_F_EXT0]};

    assign hreadyout         = 1'b1;
    assign hresp             = 1'b0;
    assign hrdata            = rdata;
    assign machine_cycle_end = mc_end;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase <= 4'h0;
        end else if (mc_end) begin
            phase <= 4'h0;
        end else begin
            phase <= phase + 4'h1;
        end
    end

    // Two-stage synchronisers; only the second stage feeds logic.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin0_sync <= 2'b11;
            pin1_sync <= 2'b11;
        end else begin
            pin0_sync <= {pin0_sync[0], ext_request_pin_0};
            pin1_sync <= {pin1_sync[0], ext_request_pin_1};
        end
    end

    // Priority resolution over the sampled requests: high level first,
    // then lowest source index, and never into an equal or higher level.
    always @* begin
        sel_valid = 1'b0;
        sel_high  = 1'b0;
        sel_src   = 3'h0;
        for (i = 5; i >= 0; i = i - 1) begin
            if (sampled[i] && level_select_reg[i] && !in_progress[1]) begin // R11 R9
                sel_valid = 1'b1;
                sel_high  = 1'b1;
                sel_src   = i[2:0];
            end
        end
        if (!sel_valid) begin
            for (i = 5; i >= 0; i = i - 1) begin
                if (sampled[i] && !level_select_reg[i] && (in_progress == 2'b00)) begin // R9
                    sel_valid = 1'b1;
                    sel_src   = i[2:0];
                end
            end
        end
    end

    // Flag update. Hardware sets win over software and vector clears.
    always @* begin
        next_flags = flags;
        if (dp_write && dp_addr == `TVIC_OFF_FLAGS) begin
            next_flags = hwdata[7:0]; // R7
        end
        if (take_call) begin
            if (sel_src == 3'h0 && edge0) next_flags[`TVIC_F_EXT0] = 1'b0; // R3
            if (sel_src == 3'h2 && edge1) next_flags[`TVIC_F_EXT1] = 1'b0; // R3
            if (sel_src == 3'h1) next_flags[`TVIC_F_TMR0] = 1'b0; // R4
            if (sel_src == 3'h3) next_flags[`TVIC_F_TMR1] = 1'b0; // R4
        end
        if (sample_pt) begin
            if (edge0) begin
                if (pin0_prev && !pin0_sync[1]) next_flags[`TVIC_F_EXT0] = 1'b1; // R2
            end else begin
                next_flags[`TVIC_F_EXT0] = !pin0_sync[1]; // R1 R18
            end
            if (edge1) begin
                if (pin1_prev && !pin1_sync[1]) next_flags[`TVIC_F_EXT1] = 1'b1; // R2
            end else begin
                next_flags[`TVIC_F_EXT1] = !pin1_sync[1]; // R1 R18
            end
        end
        if (timer0_rollover)  next_flags[`TVIC_F_TMR0] = 1'b1; // R4
        if (timer1_rollover)  next_flags[`TVIC_F_TMR1] = 1'b1; // R4
        if (rx_done)          next_flags[`TVIC_F_RX]   = 1'b1; // R5
        if (tx_done)          next_flags[`TVIC_F_TX]   = 1'b1; // R5
        if (timer2_rollover)  next_flags[`TVIC_F_T2OV] = 1'b1; // R6
        if (timer2_ext_event) next_flags[`TVIC_F_T2EX] = 1'b1; // R6
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags     <= `TVIC_RESET_BYTE;
            pin0_prev <= 1'b1;
            pin1_prev <= 1'b1;
            sampled   <= 6'h00;
        end else begin
            flags <= next_flags;
            if (sample_pt) begin
                pin0_prev <= pin0_sync[1];
                pin1_prev <= pin1_sync[1];
                // Fresh snapshot each cycle, so nothing blocked is kept.
                sampled <= req & source_enable_reg[5:0]
                         & {6{source_enable_reg[`TVIC_EN_GLOBAL]}}; // R8 R12 R14
            end
        end
    end

    // Call sequence: request held for two machine cycles with the vector.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            call_cnt    <= 2'h0;
            call_req    <= 1'b0;
            call_vector <= 16'h0000;
            call_src    <= 3'h0;
            call_high   <= 1'b0;
            in_progress <= 2'b00;
        end else begin
            // A return in the same clock as a new call must not be lost.
            if (handler_return) begin // R17
                if (in_progress[1]) in_progress[1] <= 1'b0;
                else                in_progress[0] <= 1'b0;
            end
            if (take_call) begin
                call_cnt    <= `TVIC_CALL_CYCLES; // R16
                call_req    <= 1'b1;
                call_src    <= sel_src;
                call_high   <= sel_high;
                call_vector <= `TVIC_VEC0 + {10'h000, sel_src, 3'b000}; // R15
                if (sel_high) in_progress[1] <= 1'b1;
                else          in_progress[0] <= 1'b1;
            end else if (mc_end && calling) begin
                call_cnt <= call_cnt - 2'h1;
                if (call_cnt == 2'h1) call_req <= 1'b0;
            end
        end
    end

    // AHB-Lite slave: zero wait states, writes land in the data phase.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write <= 1'b0;
            dp_read  <= 1'b0;
            dp_addr  <= 12'h000;
        end else if (hready) begin
            dp_write <= hsel && htrans[1] && hwrite;
            dp_read  <= hsel && htrans[1] && !hwrite;
            dp_addr  <= haddr;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            source_enable_reg <= `TVIC_RESET_BYTE;
            level_select_reg  <= `TVIC_RESET_BYTE;
            ctrl              <= 2'b00;
        end else if (dp_write) begin
            case (dp_addr)
            `TVIC_OFF_ENABLE: source_enable_reg <= hwdata[7:0] & `TVIC_ENABLE_MASK; // R8
            `TVIC_OFF_LEVEL:  level_select_reg  <= hwdata[7:0] & `TVIC_LEVEL_MASK;  // R10
            `TVIC_OFF_CTRL:   ctrl              <= hwdata[1:0]; // R1
            default: ;
            endcase
        end
    end

    always @* begin
        case (dp_addr)
        `TVIC_OFF_FLAGS:  rdata = {24'h000000, flags};
        `TVIC_OFF_ENABLE: rdata = {24'h000000, source_enable_reg};
        `TVIC_OFF_LEVEL:  rdata = {24'h000000, level_select_reg};
        `TVIC_OFF_STATUS: rdata = {19'h00000, call_high, call_src, call_req,
                                   in_progress, sampled};
        `TVIC_OFF_CTRL:   rdata = {30'h00000000, ctrl};
        default:          rdata = 32'h00000000;
        endcase
    end
endmodule // tvic_ctrl
`default_nettype wire

/* testbench/tvic_monitor.sv */
/* Port checker for tvic_ctrl, bound from the bench top file.
   Sees only the ports of tvic_ctrl, all in the hclk domain. */
`timescale 1ns/1ps
`default_nettype none
module tvic_monitor (
    input wire        hclk,              // clock
    input wire        hresetn,           // reset, active low
    input wire        hreadyout,         // bus ready
    input wire        hresp,             // bus response
    input wire        final_cycle,       // instruction ends
    input wire        special_instr,     // blocking instruction
    input wire        machine_cycle_end, // machine cycle ends
    input wire        call_req,          // call in progress
    input wire [15:0] call_vector        // call target
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    a_cycle_twelve: assert property (machine_cycle_end |=>
        !machine_cycle_end [*8] ##4 machine_cycle_end) else $error("machine cycle not 12");
    a_call_poll: assert property ($rose(call_req) |-> $past(machine_cycle_end) &&
        $past(final_cycle) && !$past(special_instr)) else $error("call outside a poll");
    a_call_two: assert property ($rose(call_req) |->
        call_req [*8] ##16 call_req ##1 !call_req) else $error("call not 24 clocks");
    a_call_cycles: assert property ($rose(call_req) |-> ##23 machine_cycle_end)
        else $error("call not two machine cycles");
    a_call_gap: assert property ($fell(call_req) |-> !call_req [*8])
        else $error("call restarted too soon");
    a_vec_map: assert property (call_req |-> call_vector[2:0] == 3'h3 &&
        call_vector[15:3] <= 13'h0005) else $error("illegal call vector");
    a_vec_hold: assert property (call_req && $past(call_req) |-> $stable(call_vector))
        else $error("call vector moved during call");
endmodule // tvic_monitor
`default_nettype wire

/* testbench/tvic_cpu_model.sv */
/* Behavioural CPU sequencer facing tvic_ctrl: instructions of one to
   four machine cycles, with stall and special-instruction hooks.
   Assumes the controller's machine_cycle_end pulse. */
`timescale 1ns/1ps
`default_nettype none
module tvic_cpu_model (
    input  wire hclk,              // clock
    input  wire hresetn,           // reset, active low
    input  wire machine_cycle_end, // machine cycle ends
    input  wire stall,             // keep instruction unfinished
    input  wire special_req,       // run a blocking instruction
    output wire final_cycle,       // instruction in final cycle
    output wire special_instr      // blocking instruction running
);
    reg [7:0] rnd;
    reg [1:0] left;
    // Four cycles at most, so a lone request still meets the response bound.
    assign final_cycle   = (left == 2'h0) && !stall;
    assign special_instr = special_req;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rnd  <= 8'hA5;
            left <= 2'h0;
        end else if (machine_cycle_end) begin
            rnd  <= {rnd[6:0], rnd[7] ^ rnd[5] ^ rnd[4] ^ rnd[3]};
            left <= (left == 2'h0) ? rnd[1:0] : left - 2'h1;
        end
    end
endmodule // tvic_cpu_model
`default_nettype wire

/* testbench/two_level_vectored_interrupt_ctrl_bench.sv */
/* Self-checking bench for tvic_ctrl: AHB-Lite register tasks, random
   flag and level traffic, pin modes, blocking and preemption cases.
   Needs tvic_cpu_model and tvic_monitor. */
`timescale 1ns/1ps
`default_nettype none
`include "tvic_regs.vh"
module two_level_vectored_interrupt_ctrl_bench;
    reg         hclk, hresetn, hsel, hwrite, p0, p1, t0, hret, stall, spec, q;
    reg  [11:0] haddr;
    reg  [1:0]  htrans;
    reg  [2:0]  hsize;
    reg  [31:0] hwdata, rd, seed;
    reg  [15:0] e;
    reg  [7:0]  f;
    reg  [4:0]  hw;
    wire [31:0] hrdata;
    wire        hreadyout, hresp, fc, si, call_req, mce;
    wire [15:0] cv;
    integer     errors, check_count, n, k;
    tvic_ctrl dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp,
        .ext_request_pin_0(p0), .ext_request_pin_1(p1), .timer0_rollover(t0),
        .timer1_rollover(hw[0]), .timer2_rollover(hw[1]), .timer2_ext_event(hw[2]),
        .rx_done(hw[3]), .tx_done(hw[4]), .final_cycle(fc), .special_instr(si),
        .handler_return(hret), .call_req, .call_vector(cv), .machine_cycle_end(mce));
    tvic_cpu_model cpu_u (.hclk, .hresetn, .machine_cycle_end(mce), .stall,
        .special_req(spec), .final_cycle(fc), .special_instr(si));
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Higher level first, then the lowest source number wins.
    function [15:0] expv(input [7:0] fl, input [5:0] lv);
        reg [5:0] r;
        integer   i;
        begin
            r = {fl[7] | fl[6], fl[5] | fl[4], fl[3:0]};
            if ((r & lv) != 6'h00) r = r & lv;
            expv = 16'h0000;
            for (i = 5; i >= 0; i = i - 1) if (r[i]) expv = {10'h000, i[2:0], 3'h3};
        end
    endfunction
    task final_report;
        begin
            $display("errors %0d checks %0d", errors, check_count);
            if (errors == 0 && check_count > 0) $display("Test passed");
            else $display("Test failed");
            $finish;
        end
    endtask
    task chk(input [31:0] g, input [31:0] x);
        begin
            check_count = check_count + 1;
            if (g !== x) begin
                errors = errors + 1;
                $display("mismatch at %0t: got %h expected %h", $time, g, x);
            end
        end
    endtask
    task tk(input integer c);
        repeat (c) @(posedge hclk);
    endtask
    task rdy;
        begin
            n = 0;
            do begin
                @(posedge hclk);
                n = n + 1;
            end while (hreadyout !== 1'b1 && n < 50);
            if (hreadyout !== 1'b1) begin
                errors = errors + 1;
                final_report;
            end
        end
    endtask
    task bus(input w, input [11:0] a, input [31:0] d);
        begin
            hsel <= 1'b1;
            htrans <= 2'h2;
            hwrite <= w;
            haddr <= a;
            rdy;
            htrans <= 2'h0;
            hsel <= 1'b0;
            hwdata <= d;
            rdy;
            rd = hrdata;
        end
    endtask
    task wr(input [11:0] a, input [31:0] d);
        bus(1'b1, a, d);
    endtask
    task rdc(input [11:0] a, input [31:0] x);
        begin
            bus(1'b0, a, 32'h0);
            chk(rd, x);
        end
    endtask
    task wcall(input integer m);
        begin
            n = 0;
            while (call_req !== 1'b1 && n < m) begin
                tk(1);
                n = n + 1;
            end
            if (call_req !== 1'b1) begin
                errors = errors + 1;
                final_report;
            end
        end
    endtask
    task quiet;
        begin
            q = 1'b0;
            repeat (72) begin
                tk(1);
                q = q | call_req;
            end
            chk({31'h0, q}, 32'h0);
        end
    endtask
    task ret;
        begin
            hret <= 1'b1;
            tk(1);
            hret <= 1'b0;
            tk(1);
        end
    endtask
    initial begin
        {hresetn, hsel, hwrite, t0, hret, stall, spec, q} = 8'h00;
        hw = 5'h00;
        {p0, p1} = 2'h3;
        haddr = 12'h000;
        htrans = 2'h0;
        hsize = 3'h2;
        hwdata = 32'h0;
        errors = 0;
        check_count = 0;
        seed = 32'h19423CE7;
        tk(6);
        hresetn <= 1'b1;
        tk(1);
        for (k = 0; k < 9; k = k + 1) rdc({k[9:0], 2'b00}, 32'h0);
        wr(`TVIC_OFF_LEVEL, 32'hFFFFFFFF);
        rdc(`TVIC_OFF_LEVEL, 32'h3F);
        wr(`TVIC_OFF_ENABLE, 32'hFF);
        rdc(`TVIC_OFF_ENABLE, 32'hBF);
        wr(`TVIC_OFF_ENABLE, 32'h3F);
        hw <= 5'h1F;
        tk(1);
        hw <= 5'h00;
        rdc(`TVIC_OFF_FLAGS, 32'hF8);
        wr(`TVIC_OFF_FLAGS, 32'h0);
        {p0, p1} <= 2'h0;
        tk(30);
        rdc(`TVIC_OFF_FLAGS, 32'h05);
        {p0, p1} <= 2'h3;
        tk(30);
        rdc(`TVIC_OFF_FLAGS, 32'h00);
        wr(`TVIC_OFF_CTRL, 32'h3);
        {p0, p1} <= 2'h0;
        tk(30);
        rdc(`TVIC_OFF_FLAGS, 32'h05);
        wr(`TVIC_OFF_FLAGS, 32'h0);
        tk(30);
        rdc(`TVIC_OFF_FLAGS, 32'h00);
        {p0, p1} <= 2'h3;
        wr(`TVIC_OFF_FLAGS, 32'h1);
        quiet;
        stall <= 1'b1;
        wr(`TVIC_OFF_ENABLE, 32'hBF);
        quiet;
        wr(`TVIC_OFF_FLAGS, 32'h0);
        tk(12);
        stall <= 1'b0;
        quiet;
        spec <= 1'b1;
        wr(`TVIC_OFF_FLAGS, 32'h1);
        quiet;
        spec <= 1'b0;
        wcall(200);
        chk(cv, 32'h0003);
        tk(30);
        ret;
        t0 <= 1'b1;
        tk(1);
        t0 <= 1'b0;
        wcall(200);
        chk(cv, 32'h000B);
        tk(30);
        rdc(`TVIC_OFF_FLAGS, 32'h0);
        ret;
        wr(`TVIC_OFF_LEVEL, 32'h20);
        wr(`TVIC_OFF_FLAGS, 32'h01);
        wcall(200);
        tk(30);
        wr(`TVIC_OFF_FLAGS, 32'h40);
        wcall(200);
        chk(cv, 32'h002B);
        tk(30);
        rdc(`TVIC_OFF_STATUS, 32'h1AE0);
        wr(`TVIC_OFF_FLAGS, 32'h02);
        quiet;
        ret;
        ret;
        wcall(200);
        chk(cv, 32'h000B);
        tk(30);
        ret;
        wr(`TVIC_OFF_CTRL, 32'h2);
        p0 <= 1'b0;
        wcall(200);
        tk(30);
        rdc(`TVIC_OFF_FLAGS, 32'h1);
        p0 <= 1'b1;
        tk(30);
        ret;
        wr(`TVIC_OFF_CTRL, 32'h3);
        repeat (8) begin
            seed = lfsr(seed);
            f = (seed[7:0] == 8'h00) ? 8'h01 : seed[7:0];
            e = expv(f, seed[13:8]);
            wr(`TVIC_OFF_LEVEL, {26'h0, seed[13:8]});
            wr(`TVIC_OFF_FLAGS, {24'h0, f});
            wcall(200);
            chk({31'h0, n < 72}, 32'h1);
            chk(cv, e);
            tk(30);
            rdc(`TVIC_OFF_FLAGS, f & ~((e < 16'h0023) ? 8'h01 << e[5:3] : 8'h00));
            wr(`TVIC_OFF_FLAGS, 32'h0);
            tk(12);
            ret;
        end
        final_report;
    end
endmodule // two_level_vectored_interrupt_ctrl_bench
bind tvic_ctrl tvic_monitor mon_u (.hclk, .hresetn, .hreadyout, .hresp, .final_cycle,
    .special_instr, .machine_cycle_end, .call_req, .call_vector);
`default_nettype wire
